// ---- common/dcop_pkg.sv ----
// constants shared by the channel configuration and output port logic
// assumes a single clock domain; bus strobes already synchronous to it
// Function
// - length code 00..11 gives 5..8 bits
// - parity normal, forced, none, multidrop; sense bit
// - block mode holds errors until reset
// - receiver interrupt source ready or full
// - channel mode normal, echo, local, remote
// - stop code 0..F gives 0.563..2.000 bits
// - five-bit characters add half bit, codes 0..7
// - command bit 7 zero; miscellaneous; enables
// - disabled transmitter refuses holding register writes
// - error bits travel with characters in fifo
// - error reset clears; char mode drops on read
// - status bit order break down to ready
// - pins 7..4 latch or ready flags
// - pin 3 latch, timer, b clocks
// - pin 2 latch, a clocks
// - latch-driven pins show inverted latch bit
// - mode pointer first after reset, then second
package dcop_pkg;

	// register offsets within a channel (low three address bits)
	localparam logic [2:0] OFF_MODE   = 3'h0;
	localparam logic [2:0] OFF_STATUS = 3'h1;  // read status, write rate select
	localparam logic [2:0] OFF_CMD    = 3'h2;
	localparam logic [2:0] OFF_HOLD   = 3'h3;
	// address bit 3 picks channel b for offsets below 4
	localparam int         CH_BIT     = 3;
	// shared registers at full addresses
	localparam logic [3:0] ADR_OSC    = 4'hd;  // output_source_config
	localparam logic [3:0] ADR_SET    = 4'he;  // set output latch bits
	localparam logic [3:0] ADR_CLR    = 4'hf;  // reset output latch bits

	// miscellaneous command field
	localparam int CMD_LSB = 4;
	typedef enum logic [2:0] {
		DCOP_CMD_NOP     = 3'b000,
		DCOP_CMD_PTR     = 3'b001,
		DCOP_CMD_RX_RST  = 3'b010,
		DCOP_CMD_TX_RST  = 3'b011,
		DCOP_CMD_ERR_RST = 3'b100,
		DCOP_CMD_BRK_INT = 3'b101,
		DCOP_CMD_BRK_ON  = 3'b110,
		DCOP_CMD_BRK_OFF = 3'b111
	} dcop_cmd_e;

	// channel mode field of the second mode register
	typedef enum logic [1:0] {
		DCOP_CM_NORMAL = 2'b00,
		DCOP_CM_ECHO   = 2'b01,
		DCOP_CM_LOCAL  = 2'b10,
		DCOP_CM_REMOTE = 2'b11
	} dcop_chmode_e;

	// field positions of the first and second mode registers
	localparam int M1_IRQ_SRC = 6;
	localparam int M1_ERR_BLK = 5;
	localparam int M1_PAR_LSB = 3;
	localparam int M1_LEN_LSB = 0;
	localparam int M2_CM_LSB  = 6;
	localparam int M2_STP_LSB = 0;

	// stop length in sixteenths of a bit, and the shortest character length
	localparam logic [5:0] STOP_SHORT = 6'h09;  // 0.563 at code 0
	localparam logic [5:0] STOP_LONG  = 6'h11;  // code 8 adds 17 -> 1.563
	localparam logic [5:0] STOP_HALF  = 6'h08;  // half bit for 5-bit chars
	localparam logic [3:0] CHAR_MIN   = 4'h5;

	// values after reset
	localparam logic [7:0] REG_RESET  = 8'h00;
	localparam logic [5:0] STOP_RESET = 6'h11;  // reset format is 5-bit, so code 0 takes the half bit
	localparam logic [7:0] PIN_RESET  = 8'hff;  // latch zero -> pins high
	localparam logic [7:0] READ_NONE  = 8'h00;

endpackage

// ---- src/dcop_rx_fifo.sv ----
// receive fifo of one channel: character plus its three error bits
// assumes push is refused by the receive engine while full
`timescale 1ns/1ps
`default_nettype none

module dcop_rx_fifo #(
	parameter int DEPTH = 4,
	parameter int AW    = 2
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       push,
	input  wire logic [7:0] push_data,
	input  wire logic [2:0] push_err,
	input  wire logic       pop,
	input  wire logic       flush,
	input  wire logic       err_clr,
	input  wire logic       block_mode,
	output logic      [7:0] top_data,
	output logic      [2:0] top_err,
	output logic            empty,
	output logic            full
);

	logic [7:0]  data_mem [DEPTH];
	logic [2:0]  err_mem  [DEPTH];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0]   cnt_ff;
	logic [2:0]  acc_ff;
	logic        do_push;
	logic        do_pop;

	assign empty   = (cnt_ff == '0);
	assign full    = (cnt_ff == (AW+1)'(DEPTH));
	assign do_push = push & ~full & ~flush;
	assign do_pop  = pop & ~empty & ~flush;
	assign top_data = data_mem[rp_ff];
	// in character mode an empty fifo has no top character, so it reports no stale error bits
	assign top_err  = block_mode ? acc_ff : (empty ? 3'h0 : err_mem[rp_ff]);

	// pointers; flush realigns them and leaves the stored words alone
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else if (ce) begin
			if (flush) begin
				wp_ff  <= '0;
				rp_ff  <= '0;
				cnt_ff <= '0;
			end else begin
				if (do_push)
					wp_ff <= wp_ff + 1'b1;
				if (do_pop)
					rp_ff <= rp_ff + 1'b1;
				cnt_ff <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
			end
		end
	end

	// storage; an error reset wipes the error bits of every entry but a new push keeps its bits
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		always_ff @(posedge clk) begin
			if (ce) begin
				if (do_push && wp_ff == AW'(i)) begin
					data_mem[i] <= push_data;
					err_mem[i]  <= push_err;
				end else if (err_clr) begin
					err_mem[i]  <= 3'h0;
				end
			end
		end
	end

	// block mode accumulation, held until error reset or flush
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			acc_ff <= 3'h0;
		else if (ce) begin
			if (do_push)
				acc_ff <= (err_clr ? 3'h0 : acc_ff) | push_err;
			else if (err_clr || flush)
				acc_ff <= 3'h0;
		end
	end

endmodule

`default_nettype wire

// ---- src/dcop_channel_port.sv ----
// two-channel configuration, command, status and output pin logic
// assumes a parallel host bus sampled on CLK and external serial engines
`timescale 1ns/1ps
`default_nettype none

module dcop_channel_port #(
	parameter int FIFO_DEPTH = 4
) (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        CE,
	input  wire logic        CS_N,
	input  wire logic        RD_N,
	input  wire logic        WR_N,
	input  wire logic [3:0]  ADDR,
	input  wire logic [7:0]  DIN,
	output logic      [7:0]  DOUT,
	output logic             DOUT_OE,
	input  wire logic [1:0]  RX_PUSH,
	input  wire logic [15:0] RX_DATA,
	input  wire logic [5:0]  RX_ERR,
	input  wire logic [1:0]  RX_OVERRUN,
	input  wire logic [1:0]  TX_EMPTY,
	input  wire logic [1:0]  TX_TAKE,
	input  wire logic        CT_OUT,
	input  wire logic        TXC_A_16X,
	input  wire logic        TXC_A_1X,
	input  wire logic        RXC_A_1X,
	input  wire logic        TXC_B_1X,
	input  wire logic        RXC_B_1X,
	output logic      [15:0] FORMAT_MODE,
	output logic      [15:0] CHANNEL_MODE,
	output logic      [15:0] RATE_SELECT,
	output logic      [7:0]  CHAR_BITS,
	output logic      [11:0] STOP_SIXTEENTHS,
	output logic      [1:0]  RX_ENABLE,
	output logic      [1:0]  TX_ENABLE,
	output logic      [1:0]  TX_BREAK,
	output logic      [1:0]  THR_VALID,
	output logic      [15:0] THR_DATA,
	output logic      [1:0]  RX_IRQ_COND,
	output logic      [7:0]  OUTPUT_PINS
);

	localparam int AW       = $clog2(FIFO_DEPTH);
	localparam int CH_BIT_L = dcop_pkg::CH_BIT;

	logic       rd_act_ff;
	logic       wr_act_ff;
	logic       rd_act;
	logic       wr_act;
	logic       rd_go;
	logic       wr_go;
	logic [7:0] dout_ff;
	logic       oe_ff;
	logic [7:0] opr_ff;
	logic [7:0] output_pin_source_config_ff;
	logic [7:0] pins_ff;
	logic [7:0] nxt_pins;
	logic [7:0] rd_val [2];
	logic [7:0] mr1_ff [2];
	logic [7:0] mr2_ff [2];
	logic [7:0] csr_ff [2];
	logic [7:0] thr_ff [2];
	logic [5:0] stop_ff [2];
	logic [3:0] len_ff [2];
	logic [1:0] ptr_ff;
	logic [1:0] rx_en_ff;
	logic [1:0] tx_en_ff;
	logic [1:0] brk_ff;
	logic [1:0] full_hr_ff;
	logic [1:0] ovr_ff;
	logic [1:0] irq_ff;
	logic [1:0] tx_rdy;
	logic [1:0] rx_sel;

	// accesses act once, on the first cycle a strobe is seen low
	assign rd_act = ~CS_N & ~RD_N;
	assign wr_act = ~CS_N & ~WR_N;
	assign rd_go  = rd_act & ~rd_act_ff;
	assign wr_go  = wr_act & ~wr_act_ff;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_act_ff <= 1'b0;
			wr_act_ff <= 1'b0;
		end else if (CE) begin
			rd_act_ff <= rd_act;
			wr_act_ff <= wr_act;
		end
	end

	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		logic       hit;
		logic       wr_mode;
		logic       rd_mode;
		logic       cmd_go;
		logic       wr_hold;
		logic       pop;
		logic [2:0] cmd;
		logic       rx_rst;
		logic       tx_rst;
		logic       err_rst;
		logic [7:0] top_data;
		logic [2:0] top_err;
		logic       empty;
		logic       full;
		logic [3:0] stop_code;
		logic [5:0] nxt_stop;

		assign hit     = (ADDR[CH_BIT_L] == 1'(ch)) & ~ADDR[2];
		assign wr_mode = wr_go & hit & (ADDR[2:0] == dcop_pkg::OFF_MODE);
		assign rd_mode = rd_go & hit & (ADDR[2:0] == dcop_pkg::OFF_MODE);
		assign cmd_go  = wr_go & hit & (ADDR[2:0] == dcop_pkg::OFF_CMD);
		assign wr_hold = wr_go & hit & (ADDR[2:0] == dcop_pkg::OFF_HOLD);
		assign pop     = rd_go & hit & (ADDR[2:0] == dcop_pkg::OFF_HOLD);
		// bit 7 of a command write is ignored; host keeps it zero
		assign cmd     = DIN[dcop_pkg::CMD_LSB +: 3];
		assign rx_rst  = cmd_go & (cmd == dcop_pkg::DCOP_CMD_RX_RST);
		assign tx_rst  = cmd_go & (cmd == dcop_pkg::DCOP_CMD_TX_RST);
		assign err_rst = cmd_go & (cmd == dcop_pkg::DCOP_CMD_ERR_RST);

		// mode pointer and the two mode registers behind one address
		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N) begin
				ptr_ff[ch] <= 1'b0;
				mr1_ff[ch] <= dcop_pkg::REG_RESET;
				mr2_ff[ch] <= dcop_pkg::REG_RESET;
			end else if (CE) begin
				if (cmd_go && cmd == dcop_pkg::DCOP_CMD_PTR)
					ptr_ff[ch] <= 1'b0;
				else if (wr_mode || rd_mode)
					ptr_ff[ch] <= 1'b1;
				if (wr_mode && !ptr_ff[ch])
					mr1_ff[ch] <= DIN;
				if (wr_mode && ptr_ff[ch])
					mr2_ff[ch] <= DIN;
			end
		end

		// rate select is stored and handed to the baud logic untouched
		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N)
				csr_ff[ch] <= dcop_pkg::REG_RESET;
			else if (CE && wr_go && hit && ADDR[2:0] == dcop_pkg::OFF_STATUS)
				csr_ff[ch] <= DIN;
		end

		// enables and break; disable wins over enable in one write
		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N) begin
				rx_en_ff[ch] <= 1'b0;
				tx_en_ff[ch] <= 1'b0;
				brk_ff[ch]   <= 1'b0;
			end else if (CE && cmd_go) begin
				if (rx_rst || DIN[1])
					rx_en_ff[ch] <= 1'b0;
				else if (DIN[0])
					rx_en_ff[ch] <= 1'b1;
				if (tx_rst || DIN[3])
					tx_en_ff[ch] <= 1'b0;
				else if (DIN[2])
					tx_en_ff[ch] <= 1'b1;
				if (tx_rst || cmd == dcop_pkg::DCOP_CMD_BRK_OFF)
					brk_ff[ch] <= 1'b0;
				else if (cmd == dcop_pkg::DCOP_CMD_BRK_ON)
					brk_ff[ch] <= 1'b1;
			end
		end

		// holding register; a new write beats a same-cycle take
		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N) begin
				thr_ff[ch]     <= dcop_pkg::REG_RESET;
				full_hr_ff[ch] <= 1'b0;
			end else if (CE) begin
				if (tx_rst)
					full_hr_ff[ch] <= 1'b0;
				else if (wr_hold && tx_en_ff[ch]) begin
					thr_ff[ch]     <= DIN;
					full_hr_ff[ch] <= 1'b1;
				end else if (TX_TAKE[ch])
					full_hr_ff[ch] <= 1'b0;
			end
		end

		// overrun is sticky; a report in the clearing cycle survives
		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N)
				ovr_ff[ch] <= 1'b0;
			else if (CE) begin
				if (RX_OVERRUN[ch])
					ovr_ff[ch] <= 1'b1;
				else if (err_rst || rx_rst)
					ovr_ff[ch] <= 1'b0;
			end
		end

		dcop_rx_fifo #(
			.DEPTH (FIFO_DEPTH),
			.AW    (AW)
		) u_fifo (
			.clk        (CLK),
			.rst_n      (RST_N),
			.ce         (CE),
			.push       (RX_PUSH[ch]),
			.push_data  (RX_DATA[ch*8 +: 8]),
			.push_err   (RX_ERR[ch*3 +: 3]),
			.pop        (pop),
			.flush      (rx_rst),
			.err_clr    (err_rst),
			.block_mode (mr1_ff[ch][dcop_pkg::M1_ERR_BLK]),
			.top_data   (top_data),
			.top_err    (top_err),
			.empty      (empty),
			.full       (full)
		);

		assign tx_rdy[ch] = tx_en_ff[ch] & ~full_hr_ff[ch];
		// receiver interrupt condition: ready or fifo full
		assign rx_sel[ch] = mr1_ff[ch][dcop_pkg::M1_IRQ_SRC] ? full : ~empty;

		// stop time in sixteenths: codes 8..F skip over the gap after 7
		assign stop_code = mr2_ff[ch][dcop_pkg::M2_STP_LSB +: 4];
		always_comb begin
			if (stop_code[3])
				nxt_stop = dcop_pkg::STOP_LONG + {2'h0, stop_code};
			else if (mr1_ff[ch][dcop_pkg::M1_LEN_LSB +: 2] == 2'h0)
				nxt_stop = dcop_pkg::STOP_SHORT + dcop_pkg::STOP_HALF
					+ {2'h0, stop_code};
			else
				nxt_stop = dcop_pkg::STOP_SHORT + {2'h0, stop_code};
		end

		// decoded format values, registered so the outputs come from flops
		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N) begin
				stop_ff[ch] <= dcop_pkg::STOP_RESET;
				len_ff[ch]  <= dcop_pkg::CHAR_MIN;
				irq_ff[ch]  <= 1'b0;
			end else if (CE) begin
				stop_ff[ch] <= nxt_stop;
				len_ff[ch]  <= dcop_pkg::CHAR_MIN
					+ {2'h0, mr1_ff[ch][dcop_pkg::M1_LEN_LSB +: 2]};
				irq_ff[ch]  <= rx_sel[ch];
			end
		end

		// per-channel read data; status bit order is fixed by the map
		always_comb begin
			unique case (ADDR[2:0])
				dcop_pkg::OFF_MODE:
					rd_val[ch] = ptr_ff[ch] ? mr2_ff[ch] : mr1_ff[ch];
				dcop_pkg::OFF_STATUS:
					rd_val[ch] = {top_err, ovr_ff[ch], TX_EMPTY[ch],
						tx_rdy[ch], full, ~empty};
				dcop_pkg::OFF_HOLD:
					rd_val[ch] = top_data;
				default:
					rd_val[ch] = dcop_pkg::READ_NONE;
			endcase
		end
	end

	// read bus: data is latched once per access and held while it lasts
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			dout_ff <= dcop_pkg::READ_NONE;
			oe_ff   <= 1'b0;
		end else if (CE) begin
			oe_ff <= rd_act;
			if (rd_go)
				dout_ff <= ADDR[2] ? dcop_pkg::READ_NONE : rd_val[ADDR[CH_BIT_L]];
		end
	end

	// output latch with set and reset strobes, plus its source selection
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			opr_ff  <= dcop_pkg::REG_RESET;
			output_pin_source_config_ff <= dcop_pkg::REG_RESET;
		end else if (CE && wr_go && !CS_N) begin
			if (ADDR == dcop_pkg::ADR_SET)
				opr_ff <= opr_ff | DIN;
			else if (ADDR == dcop_pkg::ADR_CLR)
				opr_ff <= opr_ff & ~DIN;
			else if (ADDR == dcop_pkg::ADR_OSC)
				output_pin_source_config_ff <= DIN;
		end
	end

	// pin sources; flags are shown active low like the latch bits
	always_comb begin
		nxt_pins    = ~opr_ff;
		if (output_pin_source_config_ff[7])
			nxt_pins[7] = ~tx_rdy[1];
		if (output_pin_source_config_ff[6])
			nxt_pins[6] = ~tx_rdy[0];
		if (output_pin_source_config_ff[5])
			nxt_pins[5] = ~rx_sel[1];
		if (output_pin_source_config_ff[4])
			nxt_pins[4] = ~rx_sel[0];
		unique case (output_pin_source_config_ff[3:2])
			2'h0: nxt_pins[3] = ~opr_ff[3];
			2'h1: nxt_pins[3] = CT_OUT;
			2'h2: nxt_pins[3] = TXC_B_1X;
			2'h3: nxt_pins[3] = RXC_B_1X;
		endcase
		unique case (output_pin_source_config_ff[1:0])
			2'h0: nxt_pins[2] = ~opr_ff[2];
			2'h1: nxt_pins[2] = TXC_A_16X;
			2'h2: nxt_pins[2] = TXC_A_1X;
			2'h3: nxt_pins[2] = RXC_A_1X;
		endcase
	end

	// pins registered; selected clocks therefore lag by one cycle
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			pins_ff <= dcop_pkg::PIN_RESET;
		else if (CE)
			pins_ff <= nxt_pins;
	end

	assign DOUT            = dout_ff;
	assign DOUT_OE         = oe_ff;
	assign OUTPUT_PINS     = pins_ff;
	assign FORMAT_MODE     = {mr1_ff[1], mr1_ff[0]};
	assign CHANNEL_MODE    = {mr2_ff[1], mr2_ff[0]};
	assign RATE_SELECT     = {csr_ff[1], csr_ff[0]};
	assign CHAR_BITS       = {len_ff[1], len_ff[0]};
	assign STOP_SIXTEENTHS = {stop_ff[1], stop_ff[0]};
	assign RX_ENABLE       = rx_en_ff;
	assign TX_ENABLE       = tx_en_ff;
	assign TX_BREAK        = brk_ff;
	assign THR_VALID       = full_hr_ff;
	assign THR_DATA        = {thr_ff[1], thr_ff[0]};
	assign RX_IRQ_COND     = irq_ff;

endmodule

`default_nettype wire

// ---- test/dcop_port_props.sv ----
// checker for the channel port: bus strobes, holding, format and pins
// assumes binding to dcop_channel_port with its ports seen as they are
`timescale 1ns/1ps
`default_nettype none
module dcop_port_props (
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        CE,
	input wire logic        CS_N,
	input wire logic        RD_N,
	input wire logic        WR_N,
	input wire logic [3:0]  ADDR,
	input wire logic [7:0]  DIN,
	input wire logic [7:0]  DOUT,
	input wire logic [1:0]  TX_EMPTY,
	input wire logic [1:0]  TX_ENABLE,
	input wire logic [1:0]  THR_VALID,
	input wire logic [7:0]  CHAR_BITS,
	input wire logic [11:0] STOP_SIXTEENTHS,
	input wire logic [7:0]  OUTPUT_PINS
);
	logic rd_q_ff;
	logic wr_q_ff;
	logic rd_tk;
	logic wr_tk;
	// a held strobe acts once, so only its first sampled cycle counts
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_q_ff <= 1'b0;
			wr_q_ff <= 1'b0;
		end else if (CE) begin
			rd_q_ff <= !CS_N && !RD_N;
			wr_q_ff <= !CS_N && !WR_N;
		end
	end
	assign rd_tk = CE && !CS_N && !RD_N && !rd_q_ff;
	assign wr_tk = CE && !CS_N && !WR_N && !wr_q_ff;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// pins 1 and 0 follow the latch only, inverted
	property p_pin_set;
		wr_tk && ADDR == 4'he && DIN[0] |-> ##[1:2] !OUTPUT_PINS[0];
	endproperty
	a_pin_set: assert property (p_pin_set) else $error("pin 0 stays high");
	property p_pin_clr;
		wr_tk && ADDR == 4'hf && DIN[1] |-> ##[1:2] OUTPUT_PINS[1];
	endproperty
	a_pin_clr: assert property (p_pin_clr) else $error("pin 1 stays low");
	// holding register of channel a
	property p_hold_refuse;
		wr_tk && ADDR == 4'h3 && !TX_ENABLE[0] && !THR_VALID[0] |=> !THR_VALID[0];
	endproperty
	a_hold_refuse: assert property (p_hold_refuse) else $error("disabled tx loaded");
	property p_hold_take;
		wr_tk && ADDR == 4'h3 && TX_ENABLE[0] |=> THR_VALID[0];
	endproperty
	a_hold_take: assert property (p_hold_take) else $error("enabled tx not loaded");
	property p_stat_tx;
		rd_tk && ADDR == 4'h1 |=>
			DOUT[3:2] == $past({TX_EMPTY[0], TX_ENABLE[0] && !THR_VALID[0]});
	endproperty
	a_stat_tx: assert property (p_stat_tx) else $error("status tx bits wrong");
	// format outputs stay within their legal spans
	property p_len_range;
		CHAR_BITS[3:0] inside {[4'h5:4'h8]} && CHAR_BITS[7:4] inside {[4'h5:4'h8]};
	endproperty
	a_len_range: assert property (p_len_range) else $error("char length out of span");
	property p_stop_range;
		STOP_SIXTEENTHS[5:0] inside {[6'h09:6'h20]};
	endproperty
	a_stop_range: assert property (p_stop_range) else $error("stop out of span");
	// the half-bit extension applies to five-bit characters only
	property p_stop_five;
		$stable(CHAR_BITS) && $stable(STOP_SIXTEENTHS) && CHAR_BITS[3:0] == 4'h5
			|-> STOP_SIXTEENTHS[5:0] >= 6'h11;
	endproperty
	a_stop_five: assert property (p_stop_five) else $error("short stop at five bits");
	property p_stop_other;
		$stable(CHAR_BITS) && $stable(STOP_SIXTEENTHS) && CHAR_BITS[3:0] != 4'h5
			|-> !(STOP_SIXTEENTHS[5:0] inside {[6'h11:6'h18]});
	endproperty
	a_stop_other: assert property (p_stop_other) else $error("stray stop extension");
	c_hold: cover property (wr_tk && ADDR == 4'h3 && TX_ENABLE[0]);
	c_stat: cover property (rd_tk && ADDR == 4'h1);
	c_pin: cover property (wr_tk && ADDR == 4'he);
endmodule
bind dcop_channel_port dcop_port_props u_dcop_port_props (
	.CLK(CLK), .RST_N(RST_N), .CE(CE), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N),
	.ADDR(ADDR), .DIN(DIN), .DOUT(DOUT), .TX_EMPTY(TX_EMPTY), .TX_ENABLE(TX_ENABLE),
	.THR_VALID(THR_VALID), .CHAR_BITS(CHAR_BITS), .STOP_SIXTEENTHS(STOP_SIXTEENTHS),
	.OUTPUT_PINS(OUTPUT_PINS)
);
`default_nettype wire

// ---- test/dcop_serial_peer.sv ----
// model of the serial engines and rate clocks beside the port
// assumes the bench calls its tasks; signals move at falling edges
`timescale 1ns/1ps
`default_nettype none
module dcop_serial_peer (
	input  wire logic        clk,
	output logic      [1:0]  rx_push,
	output logic      [15:0] rx_data,
	output logic      [5:0]  rx_err,
	output logic      [1:0]  rx_ovr,
	output logic      [1:0]  tx_empty,
	output logic      [1:0]  tx_take,
	output logic      [5:0]  clks
);
	// free dividers stand in for timer and rate clocks
	initial clks = 6'h00;
	always @(negedge clk) clks <= clks + 6'h01;
	initial begin
		rx_push = 2'h0;
		rx_data = 16'h5a5a;
		rx_err = 6'h2a;
		rx_ovr = 2'h0;
		tx_empty = 2'h3;
		tx_take = 2'h0;
	end
	// data lines flip when idle so a stale value is never mistaken
	task automatic push(input int ch, input logic [7:0] d, input logic [2:0] e);
		@(negedge clk);
		rx_push[ch] = 1'b1;
		rx_data[ch*8+:8] = d;
		rx_err[ch*3+:3] = e;
		@(negedge clk);
		rx_push = 2'h0;
		rx_data = ~rx_data;
		rx_err = ~rx_err;
	endtask
	task automatic take(input int ch);
		@(negedge clk);
		tx_take[ch] = 1'b1;
		tx_empty[ch] = 1'b0;
		@(negedge clk);
		tx_take = 2'h0;
	endtask
	task automatic ovr(input int ch);
		@(negedge clk);
		rx_ovr[ch] = 1'b1;
		@(negedge clk);
		rx_ovr = 2'h0;
	endtask
endmodule
`default_nettype wire

// ---- test/tb_dcop_channel_port.sv ----
// self-checking bench for the channel configuration and output port
// assumes the serial peer model and the bound checker are compiled too
`timescale 1ns/1ps
`default_nettype none
module tb_dcop_channel_port;
	typedef struct packed {logic [7:0] m1; logic [7:0] m2; logic [3:0] n; logic [5:0] s;} dcop_row_s;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n = 1'b1;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] din = 8'h00;
	logic [7:0] dout, d;
	logic oe, oe_q;
	logic [1:0] rx_push, rx_ovr, tx_empty, tx_take, rx_en, tx_en, brk, thr_v, irq;
	logic [15:0] rx_data, fmt, chm, rate, thr_d;
	logic [5:0] rx_err, clks, src_q;
	logic [7:0] bits, pins;
	logic [11:0] stp;
	logic [3:0] e3, e2;
	int error_cnt = 0;
	int comparisons = 0;
	dcop_row_s rows [7] = '{'{8'h00, 8'h00, 4'h5, 6'h11}, '{8'h0c, 8'h47, 4'h5, 6'h18},
		'{8'h11, 8'h88, 4'h6, 6'h19}, '{8'h1a, 8'hc0, 4'h7, 6'h09},
		'{8'h43, 8'h0f, 4'h8, 6'h20}, '{8'h02, 8'h07, 4'h7, 6'h10}, '{8'h00, 8'h0f, 4'h5, 6'h20}};
	// 250 MHz clock
	always #2 clk = ~clk;
	// sources as the pin registers see them at each rising edge
	always @(posedge clk) src_q <= clks;
	dcop_channel_port u_dcop_channel_port (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .CS_N(cs_n),
		.RD_N(rd_n), .WR_N(wr_n), .ADDR(addr), .DIN(din), .DOUT(dout), .DOUT_OE(oe),
		.RX_PUSH(rx_push), .RX_DATA(rx_data), .RX_ERR(rx_err), .RX_OVERRUN(rx_ovr),
		.TX_EMPTY(tx_empty), .TX_TAKE(tx_take), .CT_OUT(clks[5]), .TXC_A_16X(clks[0]),
		.TXC_A_1X(clks[1]), .RXC_A_1X(clks[2]), .TXC_B_1X(clks[3]), .RXC_B_1X(clks[4]),
		.FORMAT_MODE(fmt), .CHANNEL_MODE(chm), .RATE_SELECT(rate), .CHAR_BITS(bits),
		.STOP_SIXTEENTHS(stp), .RX_ENABLE(rx_en), .TX_ENABLE(tx_en), .TX_BREAK(brk),
		.THR_VALID(thr_v), .THR_DATA(thr_d), .RX_IRQ_COND(irq), .OUTPUT_PINS(pins));
	dcop_serial_peer u_dcop_serial_peer (.clk(clk), .rx_push(rx_push), .rx_data(rx_data),
		.rx_err(rx_err), .rx_ovr(rx_ovr), .tx_empty(tx_empty), .tx_take(tx_take), .clks(clks));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// strobes go low at one falling edge and return high at the next
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(negedge clk);
		{cs_n, wr_n, addr, din} = {2'b00, a, v};
		@(negedge clk);
		{cs_n, wr_n, din} = {2'b11, ~v};
	endtask
	task automatic rd(input logic [3:0] a);
		@(negedge clk);
		{cs_n, rd_n, addr} = {2'b00, a};
		@(negedge clk);
		{cs_n, rd_n} = 2'b11;
		d = dout;
		oe_q = oe;
	endtask
	// commands keep three clocks apart
	task automatic cmd(input logic [3:0] a, input logic [7:0] v);
		wr(a, v);
		repeat (3) @(negedge clk);
	endtask
	task automatic mode(input logic [3:0] b, input logic [7:0] m1, input logic [7:0] m2);
		cmd(b + 4'h2, 8'h10);
		wr(b, m1);
		wr(b, m2);
		repeat (3) @(negedge clk);
	endtask
	task automatic test_done();
		$display("mismatches %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// some 450 cycles are needed; the limit allows twenty times that
	initial begin
		#36000;
		error_cnt++;
		test_done();
	end
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		chk("pins", 8'hff, pins);
		chk("bits", 8'h55, bits);
		chk("stop", 12'h451, stp);
		chk("en", 4'h0, {rx_en, tx_en});
		chk("oe", 1'b0, oe);
		foreach (rows[i]) begin
			mode(4'h0, rows[i].m1, rows[i].m2);
			mode(4'h8, rows[i].m1, rows[i].m2);
			chk("fmt", {2{rows[i].m1}}, fmt);
			chk("chm", {2{rows[i].m2}}, chm);
			chk("bits", {2{rows[i].n}}, bits);
			chk("stop", {2{rows[i].s}}, stp);
			cmd(4'h2, 8'h10);
			rd(4'h0);
			chk("mr1", rows[i].m1, d);
			rd(4'h0);
			chk("mr2", rows[i].m2, d);
		end
		wr(4'h1, 8'hc7);
		chk("rate", 8'hc7, rate[7:0]);
		wr(4'h3, 8'h3c);
		chk("thr", 1'b0, thr_v[0]);
		cmd(4'h2, 8'h05);
		chk("en", 4'h5, {rx_en, tx_en});
		rd(4'h1);
		chk("stat", 8'h0c, d);
		chk("oe", 1'b1, oe_q);
		wr(4'h3, 8'ha5);
		chk("thr", 9'h1a5, {thr_v[0], thr_d[7:0]});
		u_dcop_serial_peer.take(0);
		rd(4'h1);
		chk("stat", 8'h04, d);
		cmd(4'h2, 8'h60);
		chk("brk", 1'b1, brk[0]);
		cmd(4'h2, 8'h70);
		chk("brk", 1'b0, brk[0]);
		// error bits ride with each character
		mode(4'h0, 8'h03, 8'h0f);
		u_dcop_serial_peer.push(0, 8'h81, 3'b100);
		u_dcop_serial_peer.push(0, 8'h42, 3'b000);
		rd(4'h1);
		chk("stat", 8'h81, d & 8'hf3);
		rd(4'h3);
		chk("data", 8'h81, d);
		rd(4'h1);
		chk("stat", 8'h01, d & 8'hf3);
		rd(4'h3);
		mode(4'h0, 8'h23, 8'h0f);
		// the accumulator also gathers in character mode; start the block clean
		cmd(4'h2, 8'h40);
		u_dcop_serial_peer.push(0, 8'h24, 3'b010);
		u_dcop_serial_peer.push(0, 8'h18, 3'b001);
		rd(4'h3);
		rd(4'h1);
		chk("stat", 8'h61, d & 8'hf3);
		cmd(4'h2, 8'h40);
		rd(4'h1);
		chk("stat", 8'h01, d & 8'hf3);
		cmd(4'h2, 8'h20);
		rd(4'h1);
		chk("stat", 8'h00, d & 8'hf3);
		cmd(4'h2, 8'h01);
		u_dcop_serial_peer.ovr(0);
		mode(4'h0, 8'h43, 8'h0f);
		repeat (4) u_dcop_serial_peer.push(0, 8'h66, 3'b000);
		rd(4'h1);
		chk("stat", 8'h13, d & 8'hf3);
		chk("irq", 1'b1, irq[0]);
		rd(4'h3);
		repeat (2) @(negedge clk);
		chk("irq", 1'b0, irq[0]);
		mode(4'h0, 8'h03, 8'h0f);
		chk("irq", 1'b1, irq[0]);
		// output pins: latch first, then routed flags and clocks
		wr(4'he, 8'hff);
		wr(4'hf, 8'h5a);
		repeat (3) @(negedge clk);
		chk("pins", 8'h5a, pins);
		wr(4'hd, 8'hf0);
		repeat (3) @(negedge clk);
		chk("pins", 8'haa, pins);
		for (int c = 0; c < 4; c++) begin
			wr(4'hd, {4'h0, c[1:0], c[1:0]});
			repeat (3) @(negedge clk);
			repeat (6) begin
				e3 = {src_q[4], src_q[3], src_q[5], 1'b1};
				e2 = {src_q[2], src_q[1], src_q[0], 1'b0};
				chk("pin3", e3[c], pins[3]);
				chk("pin2", e2[c], pins[2]);
				@(negedge clk);
			end
		end
		test_done();
	end
endmodule
`default_nettype wire
